// ==== hw/rrs_params.svh ====
`ifndef RRS_PARAMS_SVH
`define RRS_PARAMS_SVH

// register byte offsets
`define RRS_OFS_OPCODE     6'h00
`define RRS_OFS_ACC        6'h04
`define RRS_OFS_STATUS     6'h08
`define RRS_OFS_PTR        6'h0C
`define RRS_OFS_IRQCTL     6'h10
`define RRS_OFS_STACK      6'h14
`define RRS_OFS_FADDR      6'h18
`define RRS_OFS_FDATA      6'h1C
`define RRS_OFS_WDOG       6'h20
`define RRS_OFS_WAKE       6'h24

// status bit positions, status reset value and irqctl enable bit
`define RRS_ST_CARRY       0
`define RRS_ST_DCARRY      1
`define RRS_ST_ZERO        2
`define RRS_ST_STANDBY_N   3
`define RRS_ST_EXPIRY_N    4
`define RRS_ST_RESET       8'h18
`define RRS_IRQ_EN_BIT     7

// opcode encodings
`define RRS_OP_IRQ_RET     14'h0009
`define RRS_OP_RETURN      14'h0008
`define RRS_OP_STANDBY     14'h0063
`define RRS_OP_STORE_HI    7'h01
`define RRS_OP_RL_HI       6'h0D
`define RRS_OP_RR_HI       6'h0C
`define RRS_OP_RETLIT_HI   4'hD

`endif

// ==== hw/rrs_pkg.sv ====
package rrs_pkg;

    typedef enum logic [1:0] {
        PH_READY   = 2'b00,
        PH_SECOND  = 2'b01,
        PH_STANDBY = 2'b10
    } rrs_phase_e;

    typedef struct packed {
        rrs_phase_e           phase;
        logic                 waitreq;
        logic [31:0]          rdata;
        logic [7:0]           acc;
        logic [7:0]           status;
        logic [12:0]          ptr;
        logic [7:0]           irqctl;
        logic [7:0][12:0]     stack;
        logic [2:0]           sp;
        logic [6:0]           faddr;
        logic [127:0][7:0]    files;
        logic [7:0]           wdog;
        logic [7:0]           presc;
        logic                 osc_halt;
    } rrs_state_s;

endpackage

// ==== hw/rrs_core.sv ====
// Register access over Avalon-MM and the address map were left to the implementer.
`timescale 1ns/1ns
`include "rrs_params.svh"

module rrs_core import rrs_pkg::*; (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic [5:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        wake,
    output logic             osc_halted,
    output logic             global_irq_enable
);

    rrs_state_s s_r;
    rrs_state_s s_nxt;

    function automatic logic [31:0] be_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return res;
    endfunction

    logic [13:0] op;
    logic [7:0]  fval;
    logic [7:0]  rot;
    logic        take;
    logic        wr;
    logic [31:0] wv;
    logic [2:0]  sp_dn;
    logic [6:0]  fidx;
    logic [7:0]  lit;
    logic [12:0] pop_addr;
    logic        is_opw;
    logic        op_held;
    logic        is_store;
    logic        is_rot;
    logic        rot_left;
    logic        rot_to_file;
    logic        is_retlit;
    logic        is_irq_ret;
    logic        is_ret;
    logic        is_standby;
    logic        wake_req;
    logic [7:0]  rot_l;
    logic [7:0]  rot_r;
    logic [31:0] rd_word;

    // bus take and opcode field split
    always_comb begin
        take        = (avs_read || avs_write) && s_r.waitreq;
        wr          = take && avs_write;
        sp_dn       = s_r.sp - 3'h1;
        op          = avs_writedata[13:0];
        fidx        = op[6:0];
        lit         = op[7:0];
        fval        = s_r.files[fidx];
        pop_addr    = s_r.stack[sp_dn];
        is_opw      = wr && (avs_address == `RRS_OFS_OPCODE);
        op_held     = is_opw && (s_r.phase != PH_READY);
        is_store    = (op[13:7] == `RRS_OP_STORE_HI);
        rot_left    = (op[13:8] == `RRS_OP_RL_HI);
        is_rot      = rot_left || (op[13:8] == `RRS_OP_RR_HI);
        rot_to_file = op[7];
        is_retlit   = (op[13:10] == `RRS_OP_RETLIT_HI);
        is_irq_ret  = (op == `RRS_OP_IRQ_RET);
        is_ret      = (op == `RRS_OP_RETURN);
        is_standby  = (op == `RRS_OP_STANDBY);
        wake_req    = wake || (wr && avs_address == `RRS_OFS_WAKE);
    end

    // per-bit rotate through carry
    for (genvar b = 0; b < 8; b++) begin : g_rot
        if (b == 0) begin : g_lo
            assign rot_l[b] = s_r.status[`RRS_ST_CARRY];
            assign rot_r[b] = fval[1];
        end else if (b == 7) begin : g_hi
            assign rot_l[b] = fval[6];
            assign rot_r[b] = s_r.status[`RRS_ST_CARRY];
        end else begin : g_mid
            assign rot_l[b] = fval[b-1];
            assign rot_r[b] = fval[b+1];
        end
    end

    // readback word of the addressed register
    always_comb begin
        rd_word = 32'h0000_0000;
        case (avs_address)
            `RRS_OFS_OPCODE: begin
                rd_word = {31'h0, s_r.osc_halt};
            end
            `RRS_OFS_ACC: begin
                rd_word = {24'h0, s_r.acc};
            end
            `RRS_OFS_STATUS: begin
                rd_word = {24'h0, s_r.status};
            end
            `RRS_OFS_PTR: begin
                rd_word = {19'h0, s_r.ptr};
            end
            `RRS_OFS_IRQCTL: begin
                rd_word = {24'h0, s_r.irqctl};
            end
            `RRS_OFS_STACK: begin
                rd_word = {16'h0, s_r.sp, pop_addr};
            end
            `RRS_OFS_FADDR: begin
                rd_word = {25'h0, s_r.faddr};
            end
            `RRS_OFS_FDATA: begin
                rd_word = {24'h0, s_r.files[s_r.faddr]};
            end
            `RRS_OFS_WDOG: begin
                rd_word = {16'h0, s_r.presc, s_r.wdog};
            end
            default: begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    always_comb begin
        s_nxt = s_r;
        rot   = 8'h00;
        wv    = 32'h0000_0000;

        // watchdog runs freely, prescaler carries into counter
        s_nxt.presc = s_r.presc + 8'h01;
        if (s_r.presc == 8'hFF) begin
            s_nxt.wdog = s_r.wdog + 8'h01;
        end

        // bus answer lasts one cycle, then back to waiting
        if (!s_r.waitreq) begin
            s_nxt.waitreq = 1'b1;
        end

        unique case (s_r.phase)
            PH_READY: begin
            end
            // second cycle of a stack return
            PH_SECOND: begin
                s_nxt.phase = PH_READY;
            end
            PH_STANDBY: begin
                if (wake_req) begin
                    s_nxt.phase    = PH_READY;
                    s_nxt.osc_halt = 1'b0;
                end
            end
            default: begin
                s_nxt.phase = PH_READY;
            end
        endcase

        if (take) begin
            s_nxt.waitreq = 1'b0;
            s_nxt.rdata   = rd_word;
        end

        if (wr) begin
            case (avs_address)
                `RRS_OFS_ACC: begin
                    wv = be_merge({24'h0, s_r.acc}, avs_writedata,
                                  avs_byteenable);
                    s_nxt.acc = wv[7:0];
                end
                `RRS_OFS_STATUS: begin
                    wv = be_merge({24'h0, s_r.status}, avs_writedata,
                                  avs_byteenable);
                    s_nxt.status = wv[7:0];
                end
                `RRS_OFS_PTR: begin
                    wv = be_merge({19'h0, s_r.ptr}, avs_writedata,
                                  avs_byteenable);
                    s_nxt.ptr = wv[12:0];
                end
                `RRS_OFS_IRQCTL: begin
                    wv = be_merge({24'h0, s_r.irqctl}, avs_writedata,
                                  avs_byteenable);
                    s_nxt.irqctl = wv[7:0];
                end
                // push a return address
                `RRS_OFS_STACK: begin
                    wv = be_merge({19'h0, s_r.stack[s_r.sp]},
                                  avs_writedata, avs_byteenable);
                    s_nxt.stack[s_r.sp] = wv[12:0];
                    s_nxt.sp = s_r.sp + 3'h1;
                end
                `RRS_OFS_FADDR: begin
                    wv = be_merge({25'h0, s_r.faddr}, avs_writedata,
                                  avs_byteenable);
                    s_nxt.faddr = wv[6:0];
                end
                `RRS_OFS_FDATA: begin
                    wv = be_merge({24'h0, s_r.files[s_r.faddr]},
                                  avs_writedata, avs_byteenable);
                    s_nxt.files[s_r.faddr] = wv[7:0];
                end
                default: begin
                end
            endcase
        end

        // opcode writes wait while a return finishes or in standby
        if (op_held) begin
            s_nxt.waitreq = 1'b1;
            s_nxt.rdata   = s_r.rdata;
        end else if (is_opw) begin
            s_nxt.ptr = s_r.ptr + 13'h0001;
            if (is_store) begin
                s_nxt.files[fidx] = s_r.acc;
            end else if (is_rot) begin
                rot = rot_left ? rot_l : rot_r;
                s_nxt.status[`RRS_ST_CARRY] = rot_left ? fval[7] : fval[0];
                if (rot_to_file) begin
                    s_nxt.files[fidx] = rot;
                end else begin
                    s_nxt.acc = rot;
                end
            end else if (is_retlit) begin
                s_nxt.acc   = lit;
                s_nxt.ptr   = pop_addr;
                s_nxt.sp    = sp_dn;
                s_nxt.phase = PH_SECOND;
            end else if (is_irq_ret) begin
                s_nxt.ptr   = pop_addr;
                s_nxt.sp    = sp_dn;
                s_nxt.phase = PH_SECOND;
                s_nxt.irqctl[`RRS_IRQ_EN_BIT] = 1'b1;
            end else if (is_ret) begin
                s_nxt.ptr   = pop_addr;
                s_nxt.sp    = sp_dn;
                s_nxt.phase = PH_SECOND;
            end else if (is_standby) begin
                s_nxt.status[`RRS_ST_STANDBY_N] = 1'b0;
                s_nxt.status[`RRS_ST_EXPIRY_N]  = 1'b1;
                s_nxt.wdog  = 8'h00;
                s_nxt.presc = 8'h00;
                s_nxt.phase    = PH_STANDBY;
                s_nxt.osc_halt = 1'b1;
            end
            // idle and unknown codes only advance
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s_r          <= '0;
            s_r.phase    <= PH_READY;
            s_r.waitreq  <= 1'b1;
            s_r.status   <= `RRS_ST_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign avs_readdata      = s_r.rdata;
    assign avs_waitrequest   = s_r.waitreq;
    assign osc_halted        = s_r.osc_halt;
    assign global_irq_enable = s_r.irqctl[`RRS_IRQ_EN_BIT];

endmodule

// ==== tb/rrs_core_assertions.sv ====
`timescale 1ns/1ns
module rrs_chk (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        wake,
    input wire logic        osc_halted,
    input wire logic        global_irq_enable
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    a_wait_one_low: assert property (
        !avs_waitrequest |=> avs_waitrequest) else $error("long answer");
    a_no_req_idle: assert property (
        !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("answer without request");
    a_read_quick: assert property (
        avs_read && avs_waitrequest && !osc_halted |=> !avs_waitrequest)
        else $error("slow read answer");
    a_unmapped_zero: assert property (
        avs_read && avs_waitrequest && avs_address == 6'h3C && !osc_halted
        |=> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_halt_hold: assert property (
        osc_halted && !wake && !(avs_write && avs_address == 6'h24)
        |=> osc_halted) else $error("left standby without wake");
    a_halt_cause: assert property (
        $rose(osc_halted) |-> $past(avs_write && avs_address == 6'h00))
        else $error("standby without opcode");
    a_wake_leaves: assert property (
        osc_halted && wake |=> !osc_halted)
        else $error("wake did not leave standby");
    a_irq_en_rise: assert property (
        $rose(global_irq_enable) |-> $past(avs_write))
        else $error("enable rose unprompted");
    a_irq_en_fall: assert property (
        $fell(global_irq_enable) |-> $past(avs_write && avs_address == 6'h10))
        else $error("enable fell unprompted");
endmodule

bind rrs_core rrs_chk u_chk (.ref_clk(ref_clk), .nrst(nrst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .wake(wake), .osc_halted(osc_halted),
    .global_irq_enable(global_irq_enable));

// ==== tb/test_return_rotate_standby_ops.sv ====
`timescale 1ns/1ns
`include "rrs_params.svh"
module test_return_rotate_standby_ops;
    logic        ref_clk = 1'b0;
    logic        nrst = 1'b0;
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic        wake = 1'b0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        osc_halted;
    logic        global_irq_enable;
    logic [31:0] rq;
    int          err_total = 0;
    int          total_checks = 0;
    int          nw;

    always #20 ref_clk = ~ref_clk;

    rrs_core DUT (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .wake(wake), .osc_halted(osc_halted),
        .global_irq_enable(global_irq_enable));

    task automatic bus(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        avs_read      <= !w;
        avs_write     <= w;
        avs_address   <= a;
        avs_writedata <= d;
        nw = 0;
        do begin
            @(posedge ref_clk);
            nw++;
        end while (avs_waitrequest !== 1'b0);
        rq = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task wr(input logic [5:0] a, input logic [31:0] d); bus(1'b1, a, d);
    endtask
    task rd(input logic [5:0] a); bus(1'b0, a, 32'h0); endtask
    task op(input logic [13:0] c); wr(`RRS_OFS_OPCODE, {18'h0, c}); endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task t_reset;
        rd(`RRS_OFS_STATUS); chk(rq, 32'h18);
        chk(global_irq_enable, 1'b0);
        rd(6'h3C); chk(rq, 32'h0);
        $display("reset test done");
    endtask
    task t_store;
        wr(`RRS_OFS_ACC, 32'h5A);
        wr(`RRS_OFS_STATUS, 32'h07);
        wr(`RRS_OFS_PTR, 32'h10);
        op({7'h01, 7'h7F}); chk(nw, 2);
        wr(`RRS_OFS_FADDR, 32'h7F);
        rd(`RRS_OFS_FDATA); chk(rq, 32'h5A);
        rd(`RRS_OFS_STATUS); chk(rq, 32'h07);
        op(14'h0000);
        rd(`RRS_OFS_PTR); chk(rq, 32'h12);
        rd(`RRS_OFS_ACC); chk(rq, 32'h5A);
        $display("store and idle test done");
    endtask
    task t_rot;
        logic [7:0] v;
        for (int i = 0; i < 4; i++) begin
            wr(`RRS_OFS_FADDR, 32'h05);
            wr(`RRS_OFS_FDATA, 32'h41);
            wr(`RRS_OFS_STATUS, 32'h1F);
            wr(`RRS_OFS_ACC, 32'h00);
            op({2'b00, (i[1] ? 4'hC : 4'hD), i[0], 7'h05});
            v = i[1] ? 8'hA0 : 8'h83;
            rd(`RRS_OFS_STATUS); chk(rq, {27'h0, 4'hF, i[1]});
            rd(i[0] ? `RRS_OFS_FDATA : `RRS_OFS_ACC);
            chk(rq, {24'h0, v});
            rd(i[0] ? `RRS_OFS_ACC : `RRS_OFS_FDATA);
            chk(rq, i[0] ? 32'h0 : 32'h41);
        end
        $display("rotate test done");
    endtask
    task t_ret;
        wr(`RRS_OFS_STACK, 32'h0123);
        wr(`RRS_OFS_STACK, 32'h0456);
        wr(`RRS_OFS_STATUS, 32'h05);
        op(`RRS_OP_RETURN);
        rd(`RRS_OFS_PTR); chk(rq, 32'h456);
        rd(`RRS_OFS_STATUS); chk(rq, 32'h05);
        op(14'h34A5);
        op(14'h0000);
        rd(`RRS_OFS_PTR); chk(rq, 32'h124);
        rd(`RRS_OFS_ACC); chk(rq, 32'hA5);
        wr(`RRS_OFS_IRQCTL, 32'h0); chk(global_irq_enable, 1'b0);
        wr(`RRS_OFS_STACK, 32'h0ABC);
        op(`RRS_OP_IRQ_RET);
        chk(global_irq_enable, 1'b1);
        op(14'h0000);
        rd(`RRS_OFS_PTR); chk(rq, 32'hABD);
        rd(`RRS_OFS_IRQCTL); chk(rq, 32'h80);
        $display("return test done");
    endtask
    task t_standby;
        wr(`RRS_OFS_STATUS, 32'h0F);
        fork
            op(`RRS_OP_STANDBY);
            begin
                repeat (6) @(posedge ref_clk);
                chk(osc_halted, 1'b1);
                wake <= 1'b1;
                @(posedge ref_clk);
                wake <= 1'b0;
            end
        join
        @(posedge ref_clk);
        chk(osc_halted, 1'b0);
        rd(`RRS_OFS_STATUS); chk(rq, 32'h17);
        rd(`RRS_OFS_WDOG); chk(rq[7:0], 8'h00);
        chk(rq[15:8] < 8'h20, 1'b1);
        $display("standby test done");
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        t_reset;
        t_store;
        t_rot;
        t_ret;
        t_standby;
        give_verdict;
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_total++;
        give_verdict;
    end
endmodule
